// File: src/dvme_top.sv
`timescale 1ns/1ns
`default_nettype none
module dvme_top #(
    parameter int SPH_QUADS = dvme_pkg::DVME_SPH_QUADS,
    parameter int FIFO_DEPTH = dvme_pkg::DVME_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic ext_wr,
    input wire logic ext_rd,
    input wire logic [11:0] ext_addr,
    input wire logic [31:0] ext_wdata,
    output logic [31:0] ext_rdata,
    input wire logic [31:0] cycle_timer,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic [31:0] tx_in_data,
    input wire logic tx_in_last,
    input wire logic tx_frame_first,
    input wire logic tx_stream_start,
    input wire logic [12:0] tx_cycle_count,
    input wire logic [24:0] tx_ts_offset,
    input wire logic initial_delta_disable,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [31:0] tx_out_data,
    output logic tx_out_last,
    input wire logic rx_in_valid,
    input wire logic [31:0] rx_in_data,
    input wire logic rx_in_last,
    input wire logic [1:0] rx_in_ctx,
    input wire logic [3:0] header_keep_mode,
    input wire logic [3:0] rx_buffer_fill,
    input wire logic [7:0] rx_desc_branch,
    input wire logic [3:0] rx_at_frame_start,
    output logic rx_out_valid,
    output logic [31:0] rx_out_data,
    output logic rx_out_last,
    output logic [1:0] rx_out_ctx,
    output logic rx_out_sof,
    output logic frame_jump,
    output logic [1:0] frame_jump_ctx
);
    import dvme_pkg::*;

    // Cycle time arithmetic: offset wraps at 3072, count at 8000
    function automatic logic [24:0] ts_add(input logic [12:0] acc, input logic [11:0] aof,
                                           input logic [12:0] bcc, input logic [11:0] bof);
        logic [12:0] o;
        logic [13:0] c;
        logic cy;
        o = {1'b0, aof} + {1'b0, bof};
        cy = (o >= DVME_OFF_WRAP);
        if (cy) begin
            o = o - DVME_OFF_WRAP;
        end
        c = {1'b0, acc} + {1'b0, bcc} + {13'd0, cy};
        if (c >= DVME_CC_WRAP) begin
            c = c - DVME_CC_WRAP;
        end
        return {c[12:0], o[11:0]};
    endfunction

    function automatic logic [12:0] cc_sub(input logic [12:0] a, input logic [12:0] b);
        logic [13:0] d;
        d = {1'b0, a} - {1'b0, b};
        if (a < b) begin
            d = d + DVME_CC_WRAP;
        end
        return d[12:0];
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [31:0] dv_q, dv_d, link_q, link_d;
    logic [31:0] ext_rdata_q, ext_rdata_d, cfg_rdata_q, cfg_rdata_d;

    always_comb begin
        dv_d = dv_q;
        link_d = link_q;
        ext_rdata_d = ext_rdata_q;
        cfg_rdata_d = cfg_rdata_q;
        if (ext_wr) begin
            unique case (ext_addr)
                DVME_DV_SET: dv_d = dv_q | (ext_wdata & DVME_DV_MASK);
                DVME_DV_CLR: dv_d = dv_q & ~(ext_wdata & DVME_DV_MASK);
                DVME_LINK_SET: link_d = link_q | (ext_wdata & DVME_LINK_MASK);
                DVME_LINK_CLR: link_d = link_q & ~(ext_wdata & DVME_LINK_MASK);
                default: ;
            endcase
        end
        if (cfg_wr && cfg_addr == DVME_CFG_LINK) begin
            link_d = cfg_wdata & DVME_LINK_MASK;
        end
        if (ext_rd) begin
            unique case (ext_addr)
                DVME_DV_SET, DVME_DV_CLR: ext_rdata_d = dv_q & DVME_DV_MASK;
                DVME_LINK_SET, DVME_LINK_CLR: ext_rdata_d = link_q;
                default: ext_rdata_d = '0;
            endcase
        end
        if (cfg_rd) begin
            cfg_rdata_d = (cfg_addr == DVME_CFG_LINK) ? link_q : '0;
        end
    end

    // DV bits clear on reset so every context starts plain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dv_q <= DVME_DV_RST;
            link_q <= DVME_LINK_RST;
            ext_rdata_q <= '0;
            cfg_rdata_q <= '0;
        end else if (ce) begin
            dv_q <= dv_d;
            link_q <= link_d;
            ext_rdata_q <= ext_rdata_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    assign ext_rdata = ext_rdata_q;
    assign cfg_rdata = cfg_rdata_q;

    logic dv_en, mpeg_en;
    assign dv_en = link_q[DVME_BIT_DV_TS];
    assign mpeg_en = link_q[DVME_BIT_MPEG_TS];

    // ----------------------------------------------------------------
    // Transmit timestamp insertion
    // ----------------------------------------------------------------
    dvme_tx_e st_q, st_d;
    logic tag_ok_q, tag_ok_d, ff_q, ff_d, mpkt_q, mpkt_d, pend_q, pend_d;
    logic [12:0] delta_q, delta_d, delta_use, first_delta;
    logic [5:0] sph_q, sph_d;
    logic [31:0] mod_data;
    logic [24:0] ts_base, mpeg_ts;
    logic tx_acc, fifo_ready, is_sph, fmt_mpeg;

    assign tx_acc = ce & tx_in_valid & fifo_ready;
    assign tx_in_ready = fifo_ready;
    assign is_sph = (st_q == DVME_TX_DATA) && (sph_q == '0);
    assign fmt_mpeg = (tx_in_data[DVME_FMT_LSB +: 6] == DVME_FMT_MPEG);
    assign ts_base = ts_add(cycle_timer[DVME_CT_CC_LSB +: 13], cycle_timer[11:0],
                            tx_ts_offset[24:12], tx_ts_offset[11:0]);
    assign first_delta = cc_sub(tx_in_data[DVME_CT_CC_LSB +: 13], tx_cycle_count);
    // Delta is skipped entirely when the offset disables it
    assign delta_use = initial_delta_disable ? '0 : (pend_q ? first_delta : delta_q);
    assign mpeg_ts = ts_add(ts_base[24:12], ts_base[11:0], delta_use, 12'h000);

    always_comb begin
        st_d = st_q;
        tag_ok_d = tag_ok_q;
        ff_d = ff_q;
        mpkt_d = mpkt_q;
        sph_d = sph_q;
        delta_d = delta_q;
        pend_d = pend_q;
        mod_data = tx_in_data;
        unique case (st_q)
            DVME_TX_CIP1: begin
                if (dv_en && ff_q && !fmt_mpeg) begin
                    mod_data[15:0] = {ts_base[15:12], ts_base[11:0]};
                end
            end
            DVME_TX_DATA: begin
                if (mpkt_q && is_sph) begin
                    mod_data[24:0] = mpeg_ts;
                end
            end
            default: ;
        endcase
        if (tx_acc) begin
            unique case (st_q)
                DVME_TX_HDR: begin
                    tag_ok_d = (tx_in_data[DVME_TAG_LSB +: 2] == DVME_TAG_CIP);
                    ff_d = tx_frame_first;
                    mpkt_d = 1'b0;
                    st_d = DVME_TX_CIP0;
                end
                DVME_TX_CIP0: st_d = DVME_TX_CIP1;
                DVME_TX_CIP1: begin
                    mpkt_d = mpeg_en & tag_ok_q & fmt_mpeg;
                    sph_d = '0;
                    st_d = DVME_TX_DATA;
                end
                DVME_TX_DATA: begin
                    sph_d = (sph_q == 6'(SPH_QUADS - 1)) ? '0 : sph_q + 1'b1;
                    if (mpkt_q && is_sph && pend_q) begin
                        delta_d = first_delta;
                        pend_d = 1'b0;
                    end
                end
            endcase
            if (tx_in_last) begin
                st_d = DVME_TX_HDR;
            end
        end
        // A new stream start wins over the capture clearing it
        if (tx_stream_start) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= DVME_TX_HDR;
            tag_ok_q <= 1'b0;
            ff_q <= 1'b0;
            mpkt_q <= 1'b0;
            sph_q <= '0;
            delta_q <= '0;
            pend_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            tag_ok_q <= tag_ok_d;
            ff_q <= ff_d;
            mpkt_q <= mpkt_d;
            sph_q <= sph_d;
            delta_q <= delta_d;
            pend_q <= pend_d;
        end
    end

    dvme_fifo #(
        .W(33),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(tx_in_valid),
        .in_ready(fifo_ready),
        .in_data({tx_in_last, mod_data}),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data({tx_out_last, tx_out_data})
    );

    // ----------------------------------------------------------------
    // Receive strip and frame alignment
    // ----------------------------------------------------------------
    logic [3:0] strip_act, align_act, sync_q, sync_d;
    logic [1:0] qi_q, qi_d;
    logic pdrop_q, pdrop_d, rx_acc, sof, drop, jump_now;
    logic rv_q, rv_d, rl_q, rl_d, rs_q, rs_d, fj_q, fj_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0] rc_q, rc_d, fjc_q, fjc_d;

    for (genvar c = 0; c < 4; c++) begin : g_ctx
        // Header keep mode overrides both bits
        assign strip_act[c] = dv_q[c*DVME_CTX_STRIDE + DVME_STRIP_OFS]
                              & ~header_keep_mode[c];
        assign align_act[c] = strip_act[c] & dv_q[c*DVME_CTX_STRIDE + DVME_ALIGN_OFS]
                              & rx_buffer_fill[c]
                              & (rx_desc_branch[2*c +: 2] == DVME_BRANCH_ALIGN);
    end

    assign rx_acc = ce & rx_in_valid;
    assign sof = (qi_q == DVME_SOF_QUAD) && (rx_in_data[31:24] == DVME_SOF_BYTE)
                 && (rx_in_data[19:16] == DVME_SOF_NIB);
    assign jump_now = rx_acc & sof & align_act[rx_in_ctx] & sync_q[rx_in_ctx]
                      & ~rx_at_frame_start[rx_in_ctx];

    always_comb begin
        qi_d = qi_q;
        pdrop_d = pdrop_q;
        sync_d = sync_q & align_act;
        drop = 1'b0;
        if (strip_act[rx_in_ctx] && qi_q < DVME_SOF_QUAD) begin
            drop = 1'b1;
        end else if (align_act[rx_in_ctx] && qi_q == DVME_SOF_QUAD) begin
            drop = ~sync_q[rx_in_ctx] & ~sof;
        end else if (align_act[rx_in_ctx] && qi_q > DVME_SOF_QUAD) begin
            drop = pdrop_q;
        end
        if (rx_acc) begin
            if (qi_q == DVME_SOF_QUAD) begin
                pdrop_d = drop;
                if (sof && align_act[rx_in_ctx]) begin
                    sync_d[rx_in_ctx] = 1'b1;
                end
            end
            qi_d = (qi_q == 2'h3) ? qi_q : qi_q + 1'b1;
            if (rx_in_last) begin
                qi_d = '0;
                pdrop_d = 1'b0;
            end
        end
        rv_d = rx_acc & ~drop;
        rd_d = rv_d ? rx_in_data : rd_q;
        rl_d = rv_d & rx_in_last;
        rc_d = rv_d ? rx_in_ctx : rc_q;
        rs_d = rv_d & sof;
        fj_d = jump_now;
        fjc_d = jump_now ? rx_in_ctx : fjc_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qi_q <= '0;
            pdrop_q <= 1'b0;
            sync_q <= '0;
            rv_q <= 1'b0;
            rd_q <= '0;
            rl_q <= 1'b0;
            rc_q <= '0;
            rs_q <= 1'b0;
            fj_q <= 1'b0;
            fjc_q <= '0;
        end else if (ce) begin
            qi_q <= qi_d;
            pdrop_q <= pdrop_d;
            sync_q <= sync_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rl_q <= rl_d;
            rc_q <= rc_d;
            rs_q <= rs_d;
            fj_q <= fj_d;
            fjc_q <= fjc_d;
        end
    end

    assign rx_out_valid = rv_q;
    assign rx_out_data = rd_q;
    assign rx_out_last = rl_q;
    assign rx_out_ctx = rc_q;
    assign rx_out_sof = rs_q;
    assign frame_jump = fj_q;
    assign frame_jump_ctx = fjc_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_dv_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        ce && ext_rd && ext_addr == DVME_DV_CLR |=> (ext_rdata & ~DVME_DV_MASK) == '0)
        else $error("DV reserved bits read nonzero");
    a_set_alias: assert property (@(posedge clk) disable iff (rst)
        ce && ext_wr && ext_addr == DVME_DV_SET |=>
        (dv_q & $past(ext_wdata) & DVME_DV_MASK) == ($past(ext_wdata) & DVME_DV_MASK))
        else $error("set alias failed to set bits");
    a_clear_alias: assert property (@(posedge clk) disable iff (rst)
        ce && ext_wr && ext_addr == DVME_DV_CLR |=>
        (dv_q & $past(ext_wdata)) == '0 && (dv_q | $past(ext_wdata)) == ($past(dv_q) | $past(ext_wdata)))
        else $error("clear alias wrong");
    a_cfg_alias: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_wr && cfg_addr == DVME_CFG_LINK ##1 ce && !cfg_wr && !ext_wr
        ##1 ce && ext_rd && (ext_addr == DVME_LINK_SET || ext_addr == DVME_LINK_CLR)
        |=> ext_rdata == ($past(cfg_wdata, 3) & DVME_LINK_MASK))
        else $error("config write not visible in alias");
    a_strip_drop: assert property (@(posedge clk) disable iff (rst)
        rx_acc && strip_act[rx_in_ctx] && qi_q < DVME_SOF_QUAD |=> !rx_out_valid)
        else $error("CIP quadlet passed while stripping");
    a_nosync_drop: assert property (@(posedge clk) disable iff (rst)
        rx_acc && align_act[rx_in_ctx] && !sync_q[rx_in_ctx] && qi_q == DVME_SOF_QUAD && !sof
        |=> !rx_out_valid)
        else $error("data passed before frame start");
    a_jump_pulse: assert property (@(posedge clk) disable iff (rst)
        jump_now |=> frame_jump && frame_jump_ctx == $past(rx_in_ctx))
        else $error("misplaced frame start gave no jump");
    a_mpeg_off: assert property (@(posedge clk) disable iff (rst)
        tx_acc && !mpeg_en && !mpkt_q && st_q == DVME_TX_DATA |-> mod_data == tx_in_data)
        else $error("MPEG data modified while disabled");
    a_tag_filter: assert property (@(posedge clk) disable iff (rst)
        tx_acc && st_q == DVME_TX_CIP1 && !tag_ok_q ##1 tx_acc && st_q == DVME_TX_DATA
        |-> mod_data == tx_in_data)
        else $error("non CIP tagged packet modified");
    a_delta_omit: assert property (@(posedge clk) disable iff (rst)
        initial_delta_disable |-> mpeg_ts == ts_base)
        else $error("initial delta used while disabled");
endmodule
`default_nettype wire

// File: src/dvme_pkg.sv
// Summary of operation
// - DV enable bit 8 puts cycle timer plus offset into CIP SYT once per frame.
// - Bit 10 enables MPEG timestamping; clear means no MPEG substitution.
// - Default MPEG mode adds initial delta on top of the programmed offset.
// - Initial delta is first packet timestamp cycle count minus intended cycle.
// - Offset bit 31 disables the delta; only the programmed offset is used.
// - MPEG changes only tag 01b packets with CIP format 10h.
// - Link control at config F4h is aliased by set A88h and clear A8Ch.
// - Aligning context discards DV data until a frame start packet arrives.
// - Frame start is third payload quadlet bytes 1Fh then low nibble 7h.
// - Context 3 strip bit 12 drops two payload quadlets unless header kept.
// - Context 2 strip bit 8 drops two payload quadlets unless header kept.
// - Context 3 align bit 13 with branch 01b aligns, jumps on misplaced start.
// - Align bit is ignored unless strip bit set and header keep clear.
// - Context 2 align bit 9 aligns and jumps like context 3.
// - Context 1 align bit 5 aligns and jumps like context 3.
// - DV register reads zero in bits 31-14, 11-10, 7-6 and 3-2.
// - Context 1 strip bit 4 drops two payload quadlets unless header kept.
// - Context 0 strip bit 0 drops two payload quadlets unless header kept.
// - Context 0 align bit 1 aligns and jumps like context 3.
package dvme_pkg;
    localparam logic [11:0] DVME_DV_SET = 12'ha80;
    localparam logic [11:0] DVME_DV_CLR = 12'ha84;
    localparam logic [11:0] DVME_LINK_SET = 12'ha88;
    localparam logic [11:0] DVME_LINK_CLR = 12'ha8c;
    localparam logic [7:0] DVME_CFG_LINK = 8'hf4;
    localparam logic [31:0] DVME_DV_MASK = 32'h0000_3333;
    localparam logic [31:0] DVME_LINK_MASK = 32'h0000_ffff;
    localparam logic [31:0] DVME_DV_RST = 32'h0000_0000;
    localparam logic [31:0] DVME_LINK_RST = 32'h0000_0000;
    localparam int DVME_BIT_DV_TS = 8;
    localparam int DVME_BIT_MPEG_TS = 10;
    localparam int DVME_CTX_STRIDE = 4;
    localparam int DVME_STRIP_OFS = 0;
    localparam int DVME_ALIGN_OFS = 1;
    localparam int DVME_TAG_LSB = 14;
    localparam logic [1:0] DVME_TAG_CIP = 2'h1;
    localparam logic [1:0] DVME_BRANCH_ALIGN = 2'h1;
    localparam int DVME_FMT_LSB = 24;
    localparam logic [5:0] DVME_FMT_MPEG = 6'h10;
    localparam logic [7:0] DVME_SOF_BYTE = 8'h1f;
    localparam logic [3:0] DVME_SOF_NIB = 4'h7;
    localparam logic [1:0] DVME_SOF_QUAD = 2'h2;
    localparam int DVME_CT_CC_LSB = 12;
    localparam logic [12:0] DVME_OFF_WRAP = 13'd3072;
    localparam logic [13:0] DVME_CC_WRAP = 14'd8000;
    localparam int DVME_SPH_QUADS = 48;
    localparam int DVME_FIFO_DEPTH = 4;
    typedef enum logic [1:0] {
        DVME_TX_HDR = 2'h0,
        DVME_TX_CIP0 = 2'h1,
        DVME_TX_CIP1 = 2'h3,
        DVME_TX_DATA = 2'h2
    } dvme_tx_e;
endpackage

// File: src/dvme_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dvme_fifo #(
    parameter int W = 33,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];

    always_comb begin
        push = ce & in_valid & in_ready;
        pop = ce & out_valid & out_ready;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule
`default_nettype wire

// File: bench/dvme_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Link transmit side taking quadlets
// ----------------------------------------
module dvme_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    output logic tx_out_ready
);
    logic [3:0] n_q;
    // Stalled ready opens one cycle in sixteen, so the FIFO fills and still trickles
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            n_q <= 4'h0;
        end else begin
            n_q <= n_q + 4'h1;
        end
    end
    assign tx_out_ready = !stall || (n_q == 4'hf);
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dvme_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, stall = 1'b0;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0, ext_wr = 1'b0, ext_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h0, rx_desc_branch = 8'h55;
    logic [11:0] ext_addr = 12'h0;
    logic [31:0] cfg_wdata = 32'h0, ext_wdata = 32'h0, tx_in_data = 32'h0, rx_in_data = 32'h0;
    logic [31:0] cycle_timer = 32'h0000_5064, cfg_rdata, ext_rdata, tx_out_data, rx_out_data;
    logic [24:0] tx_ts_offset = 25'h00020c8;
    logic [12:0] tx_cycle_count = 13'h0;
    logic tx_in_valid = 1'b0, tx_in_last = 1'b0, tx_frame_first = 1'b0, tx_stream_start = 1'b0;
    logic initial_delta_disable = 1'b1, rx_in_valid = 1'b0, rx_in_last = 1'b0;
    logic [1:0] rx_in_ctx = 2'h0, rx_out_ctx, frame_jump_ctx;
    logic [3:0] header_keep_mode = 4'h0, rx_buffer_fill = 4'hf, rx_at_frame_start = 4'h0;
    logic tx_in_ready, tx_out_valid, tx_out_ready, tx_out_last, rx_out_valid, rx_out_last, rx_out_sof, frame_jump;
    logic rd_q = 1'b0, rd_cf = 1'b0, full_seen = 1'b0, pnd = 1'b0;
    logic [31:0] lnk = 32'h0;
    logic [34:0] q_rd[$], q_rx[$], q_tx[$], q_j[$], q_s[$];
    int n_errors = 0, checks = 0, seed = 32'ha0fe, n, dlt = 0;

    dvme_top #(.SPH_QUADS(48), .FIFO_DEPTH(4)) u_dut (.*);
    dvme_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .tx_out_ready(tx_out_ready));

    always #2 clk = ~clk;

    task automatic test_done();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pop(ref logic [34:0] q[$], input string nm, input logic [34:0] g);
        if (q.size() == 0) chk(nm, 35'hx, g);
        else chk(nm, q.pop_front(), g);
    endtask

    // ----------------------------------------
    // Drivers: on a read, d is the value expected back
    // ----------------------------------------
    task automatic acc(input logic cf, input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        cfg_wr = cf & w;
        cfg_rd = cf & !w;
        ext_wr = !cf & w;
        ext_rd = !cf & !w;
        cfg_addr = a[7:0];
        ext_addr = a;
        cfg_wdata = d;
        ext_wdata = d;
        if (!w) q_rd.push_back({3'h0, d});
        if (cf && w) lnk = d;
        @(negedge clk);
        {cfg_wr, cfg_rd, ext_wr, ext_rd} = 4'h0;
    endtask

    task automatic rxp(input logic [1:0] c, input logic [31:0] q2, input int m);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            rx_in_valid = 1'b1;
            rx_in_ctx = c;
            rx_in_last = (i == 3);
            rx_in_data = (i == 2) ? q2 : $random(seed);
            if (m == 2 || (m == 1 && i > 1)) begin
                q_rx.push_back({c, rx_in_last, rx_in_data});
                q_s.push_back({34'h0, i == 2 && q2[31:24] == 8'h1f && q2[19:16] == 4'h7});
            end
        end
        @(negedge clk);
        rx_in_valid = 1'b0;
    endtask

    task automatic txp(input logic [1:0] tag, input logic [5:0] fmt, input logic ff, input int len);
        logic [31:0] d, e;
        for (int i = 0; i < len; i++) begin
            d = $random(seed);
            if (i == 0) d = {16'h0, tag, 14'h0};
            if (i == 2) d = {2'h0, fmt, d[23:0]};
            // Keep the packet's cycle count below the 8000 wrap
            if (i == 3) d[24] = 1'b0;
            e = d;
            // Count 5+2, offset 100+200: no wrap, so the sum is exact
            if (i == 2 && lnk[8] && ff && fmt != 6'h10) e[15:0] = 16'h712c;
            if (i == 3 && lnk[10] && tag == 2'h1 && fmt == 6'h10) begin
                if (pnd) dlt = (int'(d[24:12]) + 8000 - int'(tx_cycle_count)) % 8000;
                pnd = 1'b0;
                e[24:0] = {13'((7 + (initial_delta_disable ? 0 : dlt)) % 8000), 12'h12c};
            end
            @(negedge clk);
            tx_in_valid = 1'b1;
            tx_in_data = d;
            tx_in_last = (i == len - 1);
            tx_frame_first = ff;
            q_tx.push_back({2'h0, tx_in_last, e});
            n = 0;
            // Ready only moves on the rising edge, so the falling edge shows what that edge will see
            while (!tx_in_ready && n < 300) begin
                full_seen = 1'b1;
                n++;
                @(negedge clk);
            end
            if (n == 300) chk("tx_in_ready", 35'h1, 35'h0);
            @(posedge clk);
        end
        @(negedge clk);
        tx_in_valid = 1'b0;
    endtask

    // Outputs seen at the edge are the values launched by the edge before
    always @(posedge clk) begin
        rd_q <= cfg_rd | ext_rd;
        rd_cf <= cfg_rd;
        if (rd_q) pop(q_rd, "rdata", {3'h0, rd_cf ? cfg_rdata : ext_rdata});
        if (rx_out_valid) pop(q_rx, "rx_out", {rx_out_ctx, rx_out_last, rx_out_data});
        if (rx_out_valid) pop(q_s, "rx_out_sof", {34'h0, rx_out_sof});
        if (tx_out_valid && tx_out_ready) pop(q_tx, "tx_out", {2'h0, tx_out_last, tx_out_data});
        if (frame_jump) pop(q_j, "frame_jump_ctx", {33'h0, frame_jump_ctx});
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        acc(0, 0, DVME_DV_SET, 32'h0);
        acc(0, 1, DVME_DV_SET, 32'hffff_ffff);
        acc(0, 0, DVME_DV_CLR, 32'h0000_3333);
        acc(0, 1, DVME_DV_CLR, 32'h0000_0101);
        acc(0, 0, DVME_DV_SET, 32'h0000_3232);
        acc(1, 1, {4'h0, DVME_CFG_LINK}, 32'hffff_ffff);
        acc(0, 0, DVME_LINK_CLR, 32'h0000_ffff);
        acc(0, 1, DVME_LINK_CLR, 32'h0000_fbff);
        acc(1, 0, {4'h0, DVME_CFG_LINK}, 32'h0000_0400);
        acc(0, 0, 12'ha90, 32'h0);
        acc(1, 1, {4'h0, DVME_CFG_LINK}, 32'h0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        acc(0, 0, DVME_DV_CLR, 32'h0);
        ce = 1'b0;
        acc(0, 1, DVME_DV_SET, 32'h0000_3333);
        ce = 1'b1;
        acc(0, 0, DVME_DV_CLR, 32'h0);
        $display("register test done");
        for (int c = 0; c < 4; c++) begin
            acc(0, 1, DVME_DV_SET, 32'h2 << (4 * c));
            rxp(c[1:0], 32'h1e07_0000, 2);
            acc(0, 1, DVME_DV_SET, 32'h1 << (4 * c));
            rxp(c[1:0], 32'h1e07_0000, 0);
            header_keep_mode = 4'h1 << c;
            rxp(c[1:0], 32'h1e07_0000, 2);
            header_keep_mode = 4'h0;
            rxp(c[1:0], 32'h1fa7_1234, 1);
            rx_at_frame_start = 4'h1 << c;
            rxp(c[1:0], 32'h1f57_0000, 1);
            rx_at_frame_start = 4'h0;
            q_j.push_back({33'h0, c[1:0]});
            rxp(c[1:0], 32'h1f07_0000, 1);
            acc(0, 1, DVME_DV_CLR, 32'hffff_ffff);
        end
        $display("receive test done");
        txp(2'h1, 6'h10, 1'b1, 5);
        acc(1, 1, {4'h0, DVME_CFG_LINK}, 32'h0000_0100);
        txp(2'h0, 6'h00, 1'b1, 5);
        txp(2'h0, 6'h00, 1'b0, 5);
        acc(1, 1, {4'h0, DVME_CFG_LINK}, 32'h0000_0400);
        stall = 1'b1;
        txp(2'h1, 6'h10, 1'b0, 12);
        stall = 1'b0;
        txp(2'h2, 6'h10, 1'b0, 5);
        txp(2'h1, 6'h01, 1'b0, 5);
        initial_delta_disable = 1'b0;
        tx_cycle_count = 13'd2;
        @(negedge clk);
        tx_stream_start = 1'b1;
        pnd = 1'b1;
        @(negedge clk);
        tx_stream_start = 1'b0;
        txp(2'h1, 6'h10, 1'b0, 5);
        txp(2'h1, 6'h10, 1'b0, 5);
        chk("fifo_full", 35'h1, {34'h0, full_seen});
        n = 0;
        while (q_rd.size() + q_rx.size() + q_tx.size() + q_j.size() + q_s.size() > 0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) chk("drain", 35'h0, 35'h1);
        $display("transmit test done");
        test_done();
    end
endmodule
`default_nettype wire
